// [src/uhp_pkg.sv]
`default_nettype none
package uhp_pkg;
    // Timing
    localparam int CLK_HZ = 200000000;
    localparam int BAUD_DEFAULT_BPS = 9600;
    localparam logic [2:0] BAUD_SELECT_RESET = 3'h3;
    localparam logic CTS_ENABLE_RESET = 1'b1;
    localparam logic RTS_ENABLE_RESET = 1'b0;
    localparam int HYSTERESIS_BYTES = 16;
    localparam int FRAME_DATA_BITS = 8;
    localparam int RX_DEPTH_LOG2 = 8;
    localparam int TX_DEPTH_LOG2 = 8;

    // Serial config carrier
    typedef struct packed {
        logic [2:0] baud_select;
        logic cts_enable_setting;
        logic rts_enable_setting;
    } uhp_cfg_t;

    // Status carrier
    typedef struct packed {
        logic rx_overrun;
        logic pkt_dropped;
    } uhp_stat_t;
endpackage
`default_nettype wire

// [src/uhp_mem.sv]
`default_nettype none
module uhp_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,            // System clock
    input wire logic we,             // Write strobe
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [DW-1:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [DW-1:0] rdata      // Registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Simple dual port storage
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// [src/uhp_baud.sv]
`default_nettype none
module uhp_baud (
    input wire logic clk,              // System clock
    input wire logic arst_n,           // Async reset, active low
    input wire logic [2:0] baud_select,// Rate code
    output logic tick16                // 16x oversample enable pulse
);
    // Divider for 16x rate; code 3 gives 9600 bps
    function automatic logic [15:0] div_of(input logic [2:0] sel);
        int bps;
        case (sel)
            3'h0: bps = 1200;
            3'h1: bps = 2400;
            3'h2: bps = 4800;
            3'h3: bps = uhp_pkg::BAUD_DEFAULT_BPS;
            3'h4: bps = 19200;
            3'h5: bps = 38400;
            3'h6: bps = 57600;
            default: bps = 115200;
        endcase
        div_of = 16'(uhp_pkg::CLK_HZ / (bps * 16) - 1);
    endfunction

    logic [15:0] cnt;
    wire logic [15:0] limit = div_of(baud_select);

    // Free running divider
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 16'h0000;
            tick16 <= 1'b0;
        end else begin
            tick16 <= (cnt >= limit);
            cnt <= (cnt >= limit) ? 16'h0000 : cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// [src/uhp_top.sv]
`default_nettype none
module uhp_top #(
    parameter int RXAW = uhp_pkg::RX_DEPTH_LOG2,
    parameter int TXAW = uhp_pkg::TX_DEPTH_LOG2
) (
    input wire logic clk,                     // System clock
    input wire logic arst_n,                  // Async reset, active low
    input wire logic serial_in_pin,           // Serial data from host
    output logic serial_out_pin,              // Serial data to host
    output logic cts_n,                       // Clear to send, active low
    input wire logic rts_n,                   // Host ready, active low
    input wire uhp_pkg::uhp_cfg_t cfg,        // Rate and flow settings
    input wire logic [RXAW:0] flow_threshold, // CTS threshold in bytes
    output logic radio_valid,                 // Byte to radio valid
    output logic [7:0] radio_data,            // Byte to radio
    input wire logic radio_ready,             // Radio takes byte
    input wire logic radio_busy,              // Incoming radio stream active
    input wire logic pkt_start,               // First byte of radio packet
    input wire logic [TXAW:0] pkt_len,        // Length given with pkt_start
    input wire logic pkt_valid,               // Radio payload byte valid
    input wire logic [7:0] pkt_data,          // Radio payload byte
    input wire logic stat_clear,              // Clears sticky status
    output uhp_pkg::uhp_stat_t stat,          // Sticky status flags
    output logic [RXAW:0] rx_level            // Receive buffer occupancy
);
    typedef enum logic [3:0] {
        UHP_IDLE = 4'b0001,
        UHP_START = 4'b0010,
        UHP_DATA = 4'b0100,
        UHP_STOP = 4'b1000
    } uhp_st_t;

    logic tick;
    uhp_baud u_baud (
        .clk(clk),
        .arst_n(arst_n),
        .baud_select(cfg.baud_select),
        .tick16(tick)
    );

    // ---------------- receiver ----------------
    uhp_st_t rx_st;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_done;
    wire logic rx_mid = tick && (rx_ph == 4'h7);
    wire logic rx_end = tick && (rx_ph == 4'hf);

    // Oversampled receive state machine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st <= UHP_IDLE;
            rx_ph <= 4'h0;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_ph <= rx_ph + 4'h1;
            end
            case (rx_st)
                UHP_IDLE: begin
                    rx_ph <= 4'h0;
                    if (!serial_in_pin) begin
                        rx_st <= UHP_START;
                    end
                end
                UHP_START: begin
                    if (rx_mid && serial_in_pin) begin
                        rx_st <= UHP_IDLE;
                    end else if (rx_end) begin
                        rx_st <= UHP_DATA;
                        rx_bit <= 3'h0;
                    end
                end
                UHP_DATA: begin
                    if (rx_mid) begin
                        rx_sh <= {serial_in_pin, rx_sh[7:1]};
                    end
                    if (rx_end) begin
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) begin
                            rx_st <= UHP_STOP;
                        end
                    end
                end
                UHP_STOP: begin
                    if (rx_mid) begin
                        rx_st <= UHP_IDLE;
                        rx_done <= serial_in_pin;
                    end
                end
                default: rx_st <= UHP_IDLE;
            endcase
        end
    end

    // ---------------- receive buffer ----------------
    logic [RXAW:0] rx_wp, rx_rp;
    wire logic [RXAW:0] rx_cnt = rx_wp - rx_rp;
    wire logic rx_full = rx_cnt[RXAW];
    wire logic rx_push = rx_done && !rx_full;
    wire logic rx_ovr = rx_done && rx_full;
    logic [7:0] rx_q;
    logic rx_hold;
    wire logic rx_fire = radio_valid && radio_ready;
    // Pop only into a free output stage, memory read data is not held
    wire logic rx_pop = (rx_cnt != '0) && !radio_busy && !rx_hold &&
                        (!radio_valid || rx_fire);

    uhp_mem #(.AW(RXAW), .DW(8)) u_rxmem (
        .clk(clk),
        .we(rx_push),
        .waddr(rx_wp[RXAW-1:0]),
        .wdata(rx_sh),
        .raddr(rx_rp[RXAW-1:0]),
        .rdata(rx_q)
    );

    // Pointers and output stage toward radio
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_hold <= 1'b0;
            radio_valid <= 1'b0;
            radio_data <= 8'h00;
        end else begin
            if (rx_push) begin
                rx_wp <= rx_wp + 1'b1;
            end
            if (rx_pop) begin
                rx_rp <= rx_rp + 1'b1;
            end
            if (rx_fire) begin
                radio_valid <= 1'b0;
            end
            if (rx_hold) begin
                radio_valid <= 1'b1;
                radio_data <= rx_q;
            end
            rx_hold <= rx_pop;
        end
    end
    assign rx_level = rx_cnt;

    // CTS with hysteresis
    logic cts_off;
    wire logic [RXAW:0] low_mark = flow_threshold - (RXAW+1)'(uhp_pkg::HYSTERESIS_BYTES);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cts_off <= 1'b0;
        end else if (rx_cnt >= flow_threshold) begin
            cts_off <= 1'b1;
        end else if (rx_cnt < low_mark ||
                     flow_threshold < (RXAW+1)'(uhp_pkg::HYSTERESIS_BYTES)) begin
            cts_off <= 1'b0;
        end
    end
    assign cts_n = cfg.cts_enable_setting ? cts_off : 1'b0;

    // ---------------- transmit buffer ----------------
    logic [TXAW:0] tx_wp, tx_rp;
    wire logic [TXAW:0] tx_cnt = tx_wp - tx_rp;
    wire logic [TXAW:0] tx_free = (TXAW+1)'(1 << TXAW) - tx_cnt;
    logic pkt_keep;
    wire logic pkt_fits = pkt_len <= tx_free;
    wire logic tx_push = pkt_valid && (pkt_start ? pkt_fits : pkt_keep) && !tx_cnt[TXAW];
    logic [7:0] tx_q;

    uhp_mem #(.AW(TXAW), .DW(8)) u_txmem (
        .clk(clk),
        .we(tx_push),
        .waddr(tx_wp[TXAW-1:0]),
        .wdata(pkt_data),
        .raddr(tx_rp[TXAW-1:0]),
        .rdata(tx_q)
    );

    // Packet admission and status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pkt_keep <= 1'b0;
            tx_wp <= '0;
            stat <= '0;
        end else begin
            if (pkt_start) begin
                pkt_keep <= pkt_fits;
            end
            if (tx_push) begin
                tx_wp <= tx_wp + 1'b1;
            end
            // Set wins over clear
            stat.pkt_dropped <= (pkt_start && !pkt_fits) ||
                                (stat.pkt_dropped && !stat_clear);
            stat.rx_overrun <= rx_ovr || (stat.rx_overrun && !stat_clear);
        end
    end

    // ---------------- transmitter ----------------
    uhp_st_t tx_st;
    logic [3:0] tx_ph;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_rd;
    wire logic tx_gate = cfg.rts_enable_setting && rts_n;
    wire logic tx_go = (tx_st == UHP_IDLE) && (tx_cnt != '0) && !tx_gate && !tx_rd;
    wire logic tx_bend = tick && (tx_ph == 4'hf);

    // Transmit framing state machine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st <= UHP_IDLE;
            tx_ph <= 4'h0;
            tx_bit <= 3'h0;
            tx_sh <= 8'h00;
            tx_rd <= 1'b0;
            tx_rp <= '0;
            serial_out_pin <= 1'b1;
        end else begin
            if (tick) begin
                tx_ph <= tx_ph + 4'h1;
            end
            tx_rd <= tx_go;
            case (tx_st)
                UHP_IDLE: begin
                    serial_out_pin <= 1'b1;
                    if (tx_rd) begin
                        tx_sh <= tx_q;
                        tx_rp <= tx_rp + 1'b1;
                        tx_ph <= 4'h0;
                        tx_st <= UHP_START;
                    end
                end
                UHP_START: begin
                    serial_out_pin <= 1'b0;
                    if (tx_bend) begin
                        tx_st <= UHP_DATA;
                        tx_bit <= 3'h0;
                    end
                end
                UHP_DATA: begin
                    serial_out_pin <= tx_sh[0];
                    if (tx_bend) begin
                        tx_sh <= {1'b0, tx_sh[7:1]};
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == 3'h7) begin
                            tx_st <= UHP_STOP;
                        end
                    end
                end
                UHP_STOP: begin
                    serial_out_pin <= 1'b1;
                    if (tx_bend) begin
                        tx_st <= UHP_IDLE;
                    end
                end
                default: tx_st <= UHP_IDLE;
            endcase
        end
    end

    // ---------------- assertions ----------------
    property p_idle_high;
        @(posedge clk) disable iff (!arst_n)
        (tx_st == UHP_IDLE) |=> serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");

    property p_rts_stall;
        @(posedge clk) disable iff (!arst_n)
        (tx_gate && tx_st == UHP_IDLE && !tx_rd) |=> (tx_st == UHP_IDLE && !tx_rd);
    endproperty
    a_rts_stall: assert property (p_rts_stall) else $error("sent while rts high");

    property p_cts_on;
        @(posedge clk) disable iff (!arst_n)
        (rx_cnt >= flow_threshold) |=> cts_off;
    endproperty
    a_cts_on: assert property (p_cts_on) else $error("cts not raised");

    property p_cts_hold;
        @(posedge clk) disable iff (!arst_n)
        (cts_off && rx_cnt >= low_mark &&
         flow_threshold >= (RXAW+1)'(uhp_pkg::HYSTERESIS_BYTES)) |=> cts_off;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("cts dropped early");

    property p_cts_dis;
        @(posedge clk) disable iff (!arst_n)
        !cfg.cts_enable_setting |-> !cts_n;
    endproperty
    a_cts_dis: assert property (p_cts_dis) else $error("cts not low when off");

    property p_no_fwd_busy;
        @(posedge clk) disable iff (!arst_n)
        radio_busy |=> $stable(rx_rp);
    endproperty
    a_no_fwd_busy: assert property (p_no_fwd_busy) else $error("forwarded during stream");

    property p_drop;
        @(posedge clk) disable iff (!arst_n)
        (pkt_start && !pkt_fits) |=> ($stable(tx_wp) && stat.pkt_dropped);
    endproperty
    a_drop: assert property (p_drop) else $error("partial packet stored");

    property p_ovr;
        @(posedge clk) disable iff (!arst_n)
        rx_ovr |=> stat.rx_overrun;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");

    property p_false_start;
        @(posedge clk) disable iff (!arst_n)
        (rx_st == UHP_START && rx_mid && serial_in_pin) |=> (rx_st == UHP_IDLE);
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start kept");

    c_rx_byte: cover property (@(posedge clk) disable iff (!arst_n) rx_push);
    c_tx_byte: cover property (@(posedge clk) disable iff (!arst_n) tx_st == UHP_STOP);
    c_cts: cover property (@(posedge clk) disable iff (!arst_n) $rose(cts_n));
    c_drop: cover property (@(posedge clk) disable iff (!arst_n) pkt_start && !pkt_fits);
endmodule
`default_nettype wire

// [sim/uhp_host_model.sv]
`default_nettype none
module uhp_host_model #(
    parameter int BIT_CYC = 1736
) (
    input wire logic clk,           // System clock
    input wire logic line_from_dev, // Device serial output
    input wire logic cts_n,         // Device clear to send
    output logic line_to_dev        // Host serial output
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    logic stop_bad = 1'b0;

    // Line idles high between characters
    initial line_to_dev = 1'b1;

    // Host transmit, waits while CTS is high
    task automatic send(input logic [7:0] d);
        while (cts_n !== 1'b0) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            line_to_dev = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
            repeat (BIT_CYC) @(negedge clk);
        end
    endtask

    // Short low pulse, too short to be a start bit
    task automatic glitch(input int n);
        line_to_dev = 1'b0;
        repeat (n) @(negedge clk);
        line_to_dev = 1'b1;
    endtask

    // Host receive, samples each bit near its middle
    initial begin
        logic [7:0] d;
        forever begin
            @(negedge line_from_dev);
            repeat (BIT_CYC / 2) @(negedge clk);
            if (line_from_dev === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(negedge clk);
                    d[i] = line_from_dev;
                end
                repeat (BIT_CYC) @(negedge clk);
                if (line_from_dev !== 1'b1) stop_bad = 1'b1;
                got_q.push_back(d);
            end
        end
    end
endmodule
`default_nettype wire

// [sim/test_uhp_top.sv]
`default_nettype none
module test_uhp_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = uhp_pkg::CLK_HZ / 115200;
    logic clk, arst_n, serial_in_pin, serial_out_pin, cts_n, rts_n;
    uhp_pkg::uhp_cfg_t cfg;
    uhp_pkg::uhp_stat_t stat;
    logic [8:0] flow_threshold, pkt_len, rx_level;
    logic radio_valid, radio_ready, radio_busy, pkt_start, pkt_valid, stat_clear;
    logic [7:0] radio_data, pkt_data, b;
    logic [7:0] pk[2];
    logic [31:0] lfsr = 32'h350b04ab;
    int n_fail = 0;
    int num_checks = 0;
    int k;
    logic off = 1'b0;
    logic low_seen;
    logic [8:0] thr_tab[5] = '{9'h001, 9'h011, 9'h012, 9'h001, 9'h001};
    logic en_tab[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    uhp_top dut (
        .clk(clk), .arst_n(arst_n), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .cts_n(cts_n), .rts_n(rts_n), .cfg(cfg),
        .flow_threshold(flow_threshold), .radio_valid(radio_valid),
        .radio_data(radio_data), .radio_ready(radio_ready), .radio_busy(radio_busy),
        .pkt_start(pkt_start), .pkt_len(pkt_len), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .stat_clear(stat_clear), .stat(stat), .rx_level(rx_level)
    );
    uhp_host_model #(.BIT_CYC(BIT_CYC)) host (
        .clk(clk), .line_from_dev(serial_out_pin), .cts_n(cts_n),
        .line_to_dev(serial_in_pin)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected CTS hold-off state
    function automatic logic cts_off_next(input logic prev, input int lvl, input int thr);
        if (lvl >= thr) return 1'b1;
        if (lvl < thr - 16) return 1'b0;
        return prev;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Radio packet bytes, length given with the first
    task automatic push(input logic [8:0] len, input int n);
        for (int i = 0; i < n; i++) begin
            pkt_start = (i == 0);
            pkt_len = len;
            pkt_valid = 1'b1;
            pkt_data = pk[i];
            @(negedge clk);
        end
        pkt_start = 1'b0;
        pkt_valid = 1'b0;
    endtask

    // Watchdog
    initial begin
        repeat (96000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        rts_n = 1'b0;
        cfg = '{3'h7, uhp_pkg::CTS_ENABLE_RESET, uhp_pkg::RTS_ENABLE_RESET};
        flow_threshold = 9'h080;
        radio_ready = 1'b1;
        radio_busy = 1'b1;
        pkt_start = 1'b0;
        pkt_len = 9'h000;
        pkt_valid = 1'b0;
        pkt_data = 8'h00;
        stat_clear = 1'b0;
        repeat (12) @(negedge clk);
        check("serial_out_pin", serial_out_pin, 1'b1);
        check("cts_n", cts_n, 1'b0);
        check("radio_valid", radio_valid, 1'b0);
        check("stat", stat, 2'h0);
        arst_n = 1'b1;
        // False start, then one character held while radio is busy
        repeat (4) @(negedge clk);
        host.glitch(BIT_CYC / 4);
        repeat (BIT_CYC) @(negedge clk);
        lfsr = lfsr_next(lfsr);
        b = lfsr[7:0];
        host.send(b);
        repeat (BIT_CYC) @(negedge clk);
        check("rx_level", rx_level, 9'h001);
        check("radio_valid", radio_valid, 1'b0);
        // Threshold walk across the hysteresis band, then CTS disabled
        for (int i = 0; i < 5; i++) begin
            flow_threshold = thr_tab[i];
            cfg.cts_enable_setting = en_tab[i];
            repeat (3) @(negedge clk);
            off = cts_off_next(off, 1, int'(thr_tab[i]));
            check("cts_n", cts_n, en_tab[i] & off);
        end
        cfg.cts_enable_setting = 1'b1;
        flow_threshold = 9'h080;
        radio_ready = 1'b0;
        radio_busy = 1'b0;
        k = 0;
        while (radio_valid !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        check("radio_valid", radio_valid, 1'b1);
        check("radio_data", radio_data, b);
        radio_ready = 1'b1;
        @(negedge clk);
        radio_ready = 1'b0;
        repeat (3) @(negedge clk);
        check("rx_level", rx_level, 9'h000);
        check("radio_valid", radio_valid, 1'b0);
        // Two-byte packet held back by RTS, then released
        cfg.rts_enable_setting = 1'b1;
        rts_n = 1'b1;
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            pk[i] = lfsr[7:0];
        end
        push(9'h002, 2);
        low_seen = 1'b0;
        repeat (2 * BIT_CYC) begin
            @(negedge clk);
            if (serial_out_pin !== 1'b1) low_seen = 1'b1;
        end
        check("held_line", low_seen, 1'b0);
        rts_n = 1'b0;
        k = 0;
        while (host.got_q.size() < 2 && k < 30 * BIT_CYC) begin
            @(negedge clk);
            k++;
        end
        check("tx0", host.got_q[0], pk[0]);
        check("tx1", host.got_q[1], pk[1]);
        check("stop_bit", host.stop_bad, 1'b0);
        // Oversized packet dropped whole, flag sticky until cleared
        lfsr = lfsr_next(lfsr);
        push(9'h101 + 9'(lfsr % 255), 2);
        check("pkt_dropped", stat.pkt_dropped, 1'b1);
        check("rx_overrun", stat.rx_overrun, 1'b0);
        repeat (12 * BIT_CYC) @(negedge clk);
        check("tx_count", host.got_q.size(), 2);
        stat_clear = 1'b1;
        @(negedge clk);
        stat_clear = 1'b0;
        @(negedge clk);
        check("stat", stat, 2'h0);
        // Default rate code, oversample tick spacing
        cfg.baud_select = uhp_pkg::BAUD_SELECT_RESET;
        k = 0;
        while (dut.tick !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        k = 1;
        while (dut.tick !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        check("tick_period", k, uhp_pkg::CLK_HZ / (uhp_pkg::BAUD_DEFAULT_BPS * 16));
        wrap_up();
    end
endmodule
`default_nettype wire
